// [boot_strap_pkg.sv]
package boot_strap_pkg;

    // Clock period of the sensing logic.
    localparam int CLK_PERIOD_NS = 25;

    // Straps must have settled this long before they are captured.
    localparam int SETTLE_TIME_NS = 1000;
    localparam int SETTLE_CYCLES =
        (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Receive line held low this long counts as a break.
    localparam int BREAK_TIME_NS = 100000;
    localparam int BREAK_CYCLES =
        (BREAK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int CNT_W = 12;
    localparam int STRAP_W = 3;

    // Strap codes, bit 2 down to bit 0, pulled-up reads as one.
    localparam logic [STRAP_W-1:0] SERIAL_LOAD_BOOT     = 3'h4;
    localparam logic [STRAP_W-1:0] RUN_TWO_WIRE_DEBUG   = 3'h1;
    localparam logic [STRAP_W-1:0] RUN_FOUR_WIRE_DEBUG  = 3'h0;
    localparam logic [STRAP_W-1:0] BREAK_SELECTED_BOOT  = 3'h2;
    localparam logic [STRAP_W-1:0] FACTORY_RESTORE_BOOT = 3'h3;

    // Pin positions within the strap group.
    localparam int RF_PIN_W  = 2;
    localparam int STRAP_TWO = 2;

    // Reset values.
    localparam logic [STRAP_W-1:0]  STRAP_RESET = 3'h0;
    localparam logic [CNT_W-1:0]    CNT_ZERO    = 12'h000;
    localparam logic [RF_PIN_W-1:0] RF_RESET    = 2'h0;
    localparam logic [STRAP_W-1:0]  OE_N_OFF    = 3'h7;

    // Sequencer states.
    typedef enum logic [2:0] {
        ST_SETTLE,
        ST_HOLD,
        ST_BREAK_CHECK,
        ST_RUN
    } seq_state_t;

    // Boot flow chosen from the latched code.
    typedef enum logic [1:0] {
        FLOW_NONE,
        FLOW_SERIAL_LOAD,
        FLOW_FUNCTIONAL,
        FLOW_RESTORE
    } boot_flow_t;

endpackage : boot_strap_pkg

// [boot_strap_mode_select.sv]
`timescale 1ns/1ps

module boot_strap_mode_select (
    input  wire logic                 clk_sys_in,        // 40 MHz clock.
    input  wire logic                 reset_n_in,        // Power-on reset.
    input  wire logic                 ce_in,             // Clock enable.
    input  wire logic [2:0]           boot_strap_in,     // Strap pin levels.
    output logic      [2:0]           boot_strap_out,    // Strap pin drive.
    output logic      [2:0]           boot_strap_oe_n_out, // Low drives pin.
    input  wire logic                 ext_reset_low_in,  // External reset.
    input  wire logic                 uart_rx_in,        // Serial receive.
    input  wire logic [1:0]           rf_switch_in,      // Radio switch ctl.
    input  wire logic                 app_strap_two_in,  // App value, pin 2.
    input  wire logic                 app_strap_two_en_in, // App drives pin 2.
    output logic [2:0]                strap_code_out,    // Latched code.
    output logic                      strap_valid_out,   // Code latched.
    output logic                      core_reset_n_out,  // Core out of reset.
    output boot_strap_pkg::boot_flow_t boot_flow_out,    // Chosen boot flow.
    output logic                      serial_route_out,  // Serial on pins.
    output logic                      debug_two_wire_out, // Two-wire debug.
    output logic                      debug_four_wire_out, // Four-wire debug.
    output logic                      factory_restore_out // Restore start.
);

    // Debug routing is fixed by the code alone, so both outputs share it.
    function automatic logic is_two_wire(input logic [2:0] code);
        return code == boot_strap_pkg::RUN_TWO_WIRE_DEBUG;
    endfunction : is_two_wire

    function automatic logic is_four_wire(input logic [2:0] code);
        return code == boot_strap_pkg::SERIAL_LOAD_BOOT
            || code == boot_strap_pkg::RUN_FOUR_WIRE_DEBUG
            || code == boot_strap_pkg::BREAK_SELECTED_BOOT;
    endfunction : is_four_wire

    boot_strap_pkg::seq_state_t state;
    boot_strap_pkg::seq_state_t next_state;
    logic [boot_strap_pkg::CNT_W-1:0] count;
    logic [boot_strap_pkg::CNT_W-1:0] next_count;
    logic [2:0] code;
    logic [2:0] next_code;
    logic       valid;
    logic       next_valid;
    logic       ext_prev;
    logic       next_ext_prev;
    boot_strap_pkg::boot_flow_t flow;
    boot_strap_pkg::boot_flow_t next_flow;
    logic       restore;
    logic       next_restore;
    logic [2:0] pin_out;
    logic [2:0] next_pin_out;
    logic [2:0] pin_oe_n;
    logic [2:0] next_pin_oe_n;
    logic       ext_rise;
    logic       core_run;
    logic       next_core_run;
    logic       serial_route;
    logic       next_serial_route;
    logic       two_wire;
    logic       next_two_wire;
    logic       four_wire;
    logic       next_four_wire;

    assign ext_rise = ext_reset_low_in && !ext_prev;

    // Sequencer. The code is written only once, in the settle state, so an
    // external reset never re-samples it; only a power-on reset does.
    always_comb begin
        next_state    = state;
        next_count    = count;
        next_code     = code;
        next_valid    = valid;
        next_ext_prev = ext_reset_low_in;
        next_flow     = flow;
        next_restore  = 1'b0;
        case (state)
            boot_strap_pkg::ST_SETTLE: begin
                next_count = count + 1'b1;
                if (count == boot_strap_pkg::CNT_W'(
                        boot_strap_pkg::SETTLE_CYCLES - 1)) begin
                    next_code  = boot_strap_in;
                    next_valid = 1'b1;
                    next_count = boot_strap_pkg::CNT_ZERO;
                    next_state = boot_strap_pkg::ST_HOLD;
                end
            end
            boot_strap_pkg::ST_HOLD: begin
                next_flow  = boot_strap_pkg::FLOW_NONE;
                next_count = boot_strap_pkg::CNT_ZERO;
                if (ext_rise) begin
                    case (code)
                        boot_strap_pkg::SERIAL_LOAD_BOOT: begin
                            next_flow  = boot_strap_pkg::FLOW_SERIAL_LOAD;
                            next_state = boot_strap_pkg::ST_RUN;
                        end
                        boot_strap_pkg::BREAK_SELECTED_BOOT: begin
                            next_state = boot_strap_pkg::ST_BREAK_CHECK;
                        end
                        boot_strap_pkg::FACTORY_RESTORE_BOOT: begin
                            next_flow    = boot_strap_pkg::FLOW_RESTORE;
                            next_restore = 1'b1;
                            next_state   = boot_strap_pkg::ST_RUN;
                        end
                        default: begin
                            next_flow  = boot_strap_pkg::FLOW_FUNCTIONAL;
                            next_state = boot_strap_pkg::ST_RUN;
                        end
                    endcase
                end
            end
            boot_strap_pkg::ST_BREAK_CHECK: begin
                // A high line at any point means no break is being sent.
                next_count = count + 1'b1;
                if (!ext_reset_low_in) begin
                    next_state = boot_strap_pkg::ST_HOLD;
                end else if (uart_rx_in) begin
                    next_flow  = boot_strap_pkg::FLOW_FUNCTIONAL;
                    next_state = boot_strap_pkg::ST_RUN;
                end else if (count == boot_strap_pkg::CNT_W'(
                        boot_strap_pkg::BREAK_CYCLES - 1)) begin
                    next_flow  = boot_strap_pkg::FLOW_SERIAL_LOAD;
                    next_state = boot_strap_pkg::ST_RUN;
                end
            end
            boot_strap_pkg::ST_RUN: begin
                // Serial load has no timeout; only a reset leaves it.
                if (!ext_reset_low_in) begin
                    next_state = boot_strap_pkg::ST_HOLD;
                    next_flow  = boot_strap_pkg::FLOW_NONE;
                end
            end
            default: begin
                next_state = boot_strap_pkg::ST_SETTLE;
            end
        endcase
    end

    // Pin drive and output decode. All straps float while sensing so the
    // pulls set the levels. Decoding the next values keeps every output on
    // a flip-flop without adding a cycle of latency.
    always_comb begin
        next_pin_out      = 3'h0;
        next_pin_oe_n     = boot_strap_pkg::OE_N_OFF;
        next_core_run     = (next_state == boot_strap_pkg::ST_RUN);
        next_serial_route = (next_flow == boot_strap_pkg::FLOW_SERIAL_LOAD);
        next_two_wire     = next_valid && is_two_wire(next_code);
        next_four_wire    = next_valid && is_four_wire(next_code);
        if (next_state == boot_strap_pkg::ST_RUN) begin
            next_pin_out[boot_strap_pkg::RF_PIN_W-1:0] = rf_switch_in;
            next_pin_oe_n[boot_strap_pkg::RF_PIN_W-1:0] = 2'h0;
            next_pin_out[boot_strap_pkg::STRAP_TWO] =
                app_strap_two_in;
            next_pin_oe_n[boot_strap_pkg::STRAP_TWO] =
                !app_strap_two_en_in;
        end
    end

    // State registers; the clock enable freezes everything.
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state    <= boot_strap_pkg::ST_SETTLE;
            count    <= boot_strap_pkg::CNT_ZERO;
            code     <= boot_strap_pkg::STRAP_RESET;
            valid    <= 1'b0;
            ext_prev <= 1'b0;
            flow     <= boot_strap_pkg::FLOW_NONE;
            restore  <= 1'b0;
            pin_out  <= 3'h0;
            pin_oe_n <= boot_strap_pkg::OE_N_OFF;
            core_run     <= 1'b0;
            serial_route <= 1'b0;
            two_wire     <= 1'b0;
            four_wire    <= 1'b0;
        end else if (ce_in) begin
            state    <= next_state;
            count    <= next_count;
            code     <= next_code;
            valid    <= next_valid;
            ext_prev <= next_ext_prev;
            flow     <= next_flow;
            restore  <= next_restore;
            pin_out  <= next_pin_out;
            pin_oe_n <= next_pin_oe_n;
            core_run     <= next_core_run;
            serial_route <= next_serial_route;
            two_wire     <= next_two_wire;
            four_wire    <= next_four_wire;
        end
    end

    // Outputs come straight from the flip-flops.
    assign boot_strap_out      = pin_out;
    assign boot_strap_oe_n_out = pin_oe_n;
    assign strap_code_out      = code;
    assign strap_valid_out     = valid;
    assign core_reset_n_out    = core_run;
    assign boot_flow_out       = flow;
    assign factory_restore_out = restore;
    assign serial_route_out    = serial_route;
    assign debug_two_wire_out  = two_wire;
    assign debug_four_wire_out = four_wire;

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);

    property p_code_frozen;
        valid |=> valid && $stable(code);
    endproperty
    a_code_frozen: assert property (p_code_frozen)
        else $error("Latched strap code changed after capture.");

    property p_latched_first;
        $rose(core_reset_n_out) |-> valid && $past(valid);
    endproperty
    a_latched_first: assert property (p_latched_first)
        else $error("Core left reset before the straps were latched.");

    property p_serial_load;
        (ce_in && state == boot_strap_pkg::ST_HOLD && ext_rise
            && code == boot_strap_pkg::SERIAL_LOAD_BOOT)
        |=> core_reset_n_out && serial_route_out && debug_four_wire_out;
    endproperty
    a_serial_load: assert property (p_serial_load)
        else $error("Serial load code did not start a serial load.");

    property p_two_wire;
        (valid && code == boot_strap_pkg::RUN_TWO_WIRE_DEBUG)
        |-> debug_two_wire_out && !debug_four_wire_out
            && flow != boot_strap_pkg::FLOW_SERIAL_LOAD;
    endproperty
    a_two_wire: assert property (p_two_wire)
        else $error("Two-wire code gave the wrong debug routing.");

    property p_four_wire;
        (ce_in && state == boot_strap_pkg::ST_HOLD && ext_rise
            && code == boot_strap_pkg::RUN_FOUR_WIRE_DEBUG)
        |=> flow == boot_strap_pkg::FLOW_FUNCTIONAL && debug_four_wire_out
            && !debug_two_wire_out;
    endproperty
    a_four_wire: assert property (p_four_wire)
        else $error("Four-wire code did not boot functionally.");

    property p_no_break;
        (ce_in && state == boot_strap_pkg::ST_BREAK_CHECK && uart_rx_in
            && ext_reset_low_in)
        |=> flow == boot_strap_pkg::FLOW_FUNCTIONAL && debug_four_wire_out;
    endproperty
    a_no_break: assert property (p_no_break)
        else $error("Idle receive line did not give a functional boot.");

    property p_restore;
        (ce_in && state == boot_strap_pkg::ST_HOLD && ext_rise
            && code == boot_strap_pkg::FACTORY_RESTORE_BOOT)
        |=> factory_restore_out && flow == boot_strap_pkg::FLOW_RESTORE;
    endproperty
    a_restore: assert property (p_restore)
        else $error("Reset release with restore code did not start restore.");

    property p_restore_cause;
        $rose(factory_restore_out)
        |-> code == boot_strap_pkg::FACTORY_RESTORE_BOOT && $past(ext_rise);
    endproperty
    a_restore_cause: assert property (p_restore_cause)
        else $error("Restore started without the restore code.");

    property p_rf_drive;
        (ce_in && next_state == boot_strap_pkg::ST_RUN)
        |=> boot_strap_oe_n_out[1:0] == 2'h0
            && boot_strap_out[1:0] == $past(rf_switch_in);
    endproperty
    a_rf_drive: assert property (p_rf_drive)
        else $error("Radio switch pins not driven after boot.");

    c_serial: cover property (serial_route_out && core_reset_n_out);
    c_break: cover property (state == boot_strap_pkg::ST_BREAK_CHECK
        ##1 flow == boot_strap_pkg::FLOW_SERIAL_LOAD);
    c_restore: cover property (factory_restore_out);
    c_two_wire: cover property (debug_two_wire_out && core_reset_n_out);

endmodule : boot_strap_mode_select

// [strap_board.sv]
`timescale 1ns/1ps

module strap_board (
    input  wire logic [2:0] pull_up_in,    // One where a pull-up is fitted.
    input  wire logic [2:0] drive_in,      // Device drive values.
    input  wire logic [2:0] drive_oe_n_in, // Low where the device drives.
    input  wire logic       rx_break_in,   // Loader holds a break.
    output logic      [2:0] pin_out,       // Resolved pin levels.
    output logic            rx_out         // Receive line level.
);
    // A released pin falls back to its resistor, never to its last level.
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pin_out[i] = drive_oe_n_in[i] ? pull_up_in[i] : drive_in[i];
        end
    end

    // The idle receive line is pulled high; a loader break holds it low.
    assign rx_out = rx_break_in ? 1'b0 : 1'b1;
endmodule : strap_board

// [tb_boot_strap_mode_select.sv]
`timescale 1ns/1ps

module tb_boot_strap_mode_select;
    logic       clk_sys_in = 1'b0;
    logic       reset_n = 1'b0;
    logic       ce = 1'b1;
    logic [2:0] pull_up = 3'h0;
    logic       ext_low = 1'b0;
    logic       rx_break = 1'b0;
    logic [1:0] rf_sw = 2'h0;
    logic       app_val = 1'b0;
    logic       app_en = 1'b0;
    logic [2:0] pins, s_out, s_oe_n, code_q;
    logic       rx, valid, core_n, ser, two, four, restore;
    boot_strap_pkg::boot_flow_t flow;
    int         failures = 0;
    int         cmp_count = 0;

    always #12.5 clk_sys_in = ~clk_sys_in;

    strap_board i_strap_board (.pull_up_in(pull_up), .drive_in(s_out),
        .drive_oe_n_in(s_oe_n), .rx_break_in(rx_break), .pin_out(pins),
        .rx_out(rx));

    boot_strap_mode_select i_boot_strap_mode_select (
        .clk_sys_in(clk_sys_in), .reset_n_in(reset_n), .ce_in(ce),
        .boot_strap_in(pins), .boot_strap_out(s_out),
        .boot_strap_oe_n_out(s_oe_n), .ext_reset_low_in(ext_low),
        .uart_rx_in(rx), .rf_switch_in(rf_sw), .app_strap_two_in(app_val),
        .app_strap_two_en_in(app_en), .strap_code_out(code_q),
        .strap_valid_out(valid), .core_reset_n_out(core_n),
        .boot_flow_out(flow), .serial_route_out(ser),
        .debug_two_wire_out(two), .debug_four_wire_out(four),
        .factory_restore_out(restore));

    task automatic chk_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t bit got %b exp %b", $time, got, exp);
        end
    endtask : chk_bit

    task automatic chk_code(input logic [2:0] got, input logic [2:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t code got %h exp %h", $time, got, exp);
        end
    endtask : chk_code

    task automatic chk_flow(input boot_strap_pkg::boot_flow_t got,
                            input boot_strap_pkg::boot_flow_t exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t flow got %0d exp %0d", $time, got, exp);
        end
    endtask : chk_flow

    // Power cycle with new straps; a stalled enable stretches the settle.
    task automatic power_up(input logic [2:0] code);
        int n;
        @(negedge clk_sys_in);
        reset_n = 1'b0;
        ext_low = 1'b0;
        rx_break = 1'b0;
        app_en = 1'b0;
        pull_up = code;
        rf_sw = ~code[1:0];
        repeat (10) @(negedge clk_sys_in);
        chk_bit(valid, 1'b0);
        chk_code(s_oe_n, 3'h7);
        reset_n = 1'b1;
        ce = 1'b0;
        repeat (5) @(negedge clk_sys_in);
        ce = 1'b1;
        n = 5;
        while (valid !== 1'b1 && n < 200) begin
            @(negedge clk_sys_in);
            n++;
        end
        chk_bit(n == 45, 1'b1);
        chk_code(code_q, code);
        chk_bit(core_n, 1'b0);
    endtask : power_up

    // Rising external reset; outputs are judged just after the edge that
    // sees it, while the one-cycle restore pulse still stands.
    task automatic boot();
        ext_low = 1'b1;
        @(posedge clk_sys_in);
        @(negedge clk_sys_in);
    endtask : boot

    task automatic chk_run(input boot_strap_pkg::boot_flow_t f,
                           input logic [3:0] flags);
        chk_bit(core_n, 1'b1);
        chk_flow(flow, f);
        chk_bit(ser, flags[3]);
        chk_bit(two, flags[2]);
        chk_bit(four, flags[1]);
        chk_bit(restore, flags[0]);
        chk_code({1'b1, s_oe_n[1:0]}, 3'h4);
        chk_code({1'b0, s_out[1:0]}, {1'b0, rf_sw});
    endtask : chk_run

    // Strap codes 4, 1, 0, 3 and 7 in turn, each after its own power cycle.
    task automatic t_codes();
        logic [2:0] c [5] = '{3'h4, 3'h1, 3'h0, 3'h3, 3'h7};
        boot_strap_pkg::boot_flow_t f [5] = '{
            boot_strap_pkg::FLOW_SERIAL_LOAD, boot_strap_pkg::FLOW_FUNCTIONAL,
            boot_strap_pkg::FLOW_FUNCTIONAL, boot_strap_pkg::FLOW_RESTORE,
            boot_strap_pkg::FLOW_FUNCTIONAL};
        logic [3:0] fl [5] = '{4'hA, 4'h4, 4'h2, 4'h1, 4'h0};
        for (int i = 0; i < 5; i++) begin
            power_up(c[i]);
            boot();
            chk_run(f[i], fl[i]);
            @(negedge clk_sys_in);
            chk_bit(restore, 1'b0);
        end
    endtask : t_codes

    // Break-selected code, with the receive line idle or held low.
    task automatic t_break(input logic brk);
        power_up(3'h2);
        rx_break = brk;
        boot();
        chk_bit(core_n, 1'b0);
        if (brk) begin
            repeat (3999) @(posedge clk_sys_in);
            @(negedge clk_sys_in);
            chk_bit(core_n, 1'b0);
            @(negedge clk_sys_in);
            chk_run(boot_strap_pkg::FLOW_SERIAL_LOAD, 4'hA);
        end else begin
            @(negedge clk_sys_in);
            chk_run(boot_strap_pkg::FLOW_FUNCTIONAL, 4'h2);
        end
    endtask : t_break

    // External reset re-entry keeps the code; strap two serves the app.
    task automatic t_hold();
        power_up(3'h1);
        boot();
        pull_up = 3'h6;
        ext_low = 1'b0;
        repeat (2) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        chk_bit(core_n, 1'b0);
        chk_flow(flow, boot_strap_pkg::FLOW_NONE);
        chk_code(s_oe_n, 3'h7);
        boot();
        chk_code(code_q, 3'h1);
        chk_run(boot_strap_pkg::FLOW_FUNCTIONAL, 4'h4);
        for (int v = 0; v < 2; v++) begin
            app_en = 1'b1;
            app_val = v[0];
            @(negedge clk_sys_in);
            @(negedge clk_sys_in);
            chk_bit(s_oe_n[2], 1'b0);
            chk_bit(s_out[2], v[0]);
        end
        app_en = 1'b0;
        @(negedge clk_sys_in);
        @(negedge clk_sys_in);
        chk_bit(s_oe_n[2], 1'b1);
    endtask : t_hold

    task automatic summarize();
        if (failures == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize

    // The whole run needs some 4500 cycles; 20000 means a hang.
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        failures++;
        summarize();
    end

    initial begin
        repeat (10) @(negedge clk_sys_in);
        t_codes();
        t_break(1'b0);
        t_break(1'b1);
        t_hold();
        summarize();
    end
endmodule : tb_boot_strap_mode_select
